/* File: common/nc_params.svh */
// nc_params.svh: opcode values, field codes, reset values and counts for
// the nibble core decoder.
// assumes: included by bare name after nc_pkg is compiled.
`ifndef NC_PARAMS_SVH
`define NC_PARAMS_SVH

`define NC_OP_CLRA    8'h00
`define NC_OP_XOR     8'h02
`define NC_OP_COMPLEMENT_ADD_CARRY    8'h10
`define NC_OP_SKC     8'h20
`define NC_OP_SKE     8'h21
`define NC_OP_SC      8'h22
`define NC_OP_DIRECT  8'h23
`define NC_OP_ASC     8'h30
`define NC_OP_ADD     8'h31
`define NC_OP_RC      8'h32
`define NC_OP_EXT     8'h33
`define NC_OP_COMP    8'h40
`define NC_OP_TICK    8'h41
`define NC_OP_RET     8'h48
`define NC_OP_SUBROUTINE_EXIT_SKIP   8'h49
`define NC_OP_CBA     8'h4E
`define NC_OP_XAS     8'h4F
`define NC_OP_CAB     8'h50
`define NC_OP_TABLE_TO_OUTPUT_LATCH    8'hBF
`define NC_OP_JID     8'hFF

`define NC_X2_SKIP_PORT_ALL_ZERO    8'h21
`define NC_X2_PULSE_LATCH_READ    8'h29
`define NC_X2_INL     8'h2E

`define NC_HI_IMMEDIATE_ADD_SKIP    4'h5
`define NC_HI_OGI     4'h5
`define NC_HI_JMP     4'h6
`define NC_HI_STORE_IMMEDIATE_STEP    4'h7
`define NC_LO_XIS     2'h0
`define NC_LO_LD      2'h1
`define NC_LO_X       2'h2
`define NC_LO_XDS     2'h3

`define NC_PAGE_CALL  5'h02
`define NC_PAGE_P23   4'h1
`define NC_RST_PC     11'h000
`define NC_TB_DIV     1024

`endif

/* File: common/nc_pkg.sv */
// nc_pkg: types shared by the nibble core decoder and its save stack.
// assumes: compiled before any design file.
package nc_pkg;

    typedef enum logic [1:0] {ST_OP1, ST_OP2, ST_IND} nc_state_t;

    typedef enum logic [1:0] {STK_HOLD, STK_PUSH, STK_POP, STK_DUPB}
        nc_stk_op_t;

endpackage : nc_pkg

/* File: src/nc_save_stack.sv */
// nc_save_stack: three-level program counter save stack.
// assumes: one operation per clock chosen by the decoder.
`timescale 1ns/1ps
`default_nettype none

module nc_save_stack #(
    parameter int AW = 11
) (
    input  wire logic               core_clk_i,
    input  wire logic               rst_n_i,
    input  wire nc_pkg::nc_stk_op_t op_i,
    input  wire logic [AW-1:0]      push_i,
    output logic      [AW-1:0]      top_o
);
    import nc_pkg::*;

    logic [AW-1:0] sa_q;
    logic [AW-1:0] sb_q;
    logic [AW-1:0] sc_q;

    assign top_o = sa_q;

    // a pop leaves the bottom level as it was
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sa_q <= '0;
            sb_q <= '0;
            sc_q <= '0;
        end else begin
            case (op_i)
                STK_PUSH: begin
                    sa_q <= push_i;
                    sb_q <= sa_q;
                    sc_q <= sb_q;
                end
                STK_POP: begin
                    sa_q <= sb_q;
                    sb_q <= sc_q;
                end
                STK_DUPB: sc_q <= sb_q;
                default: ;
            endcase
        end
    end

endmodule : nc_save_stack

`default_nettype wire

/* File: src/nc_ram.sv */
// nc_ram: nibble data memory, row and digit addressed.
// assumes: combinational read, one write per clock; never cleared.
`timescale 1ns/1ps
`default_nettype none

module nc_ram #(
    parameter int ROWS   = 8,
    parameter int DIGITS = 16,
    parameter int IW     = $clog2(ROWS * DIGITS)
) (
    input  wire logic          core_clk_i,
    input  wire logic [IW-1:0] raddr_i,
    output logic      [3:0]    rdata_o,
    input  wire logic          we_i,
    input  wire logic [IW-1:0] waddr_i,
    input  wire logic [3:0]    wdata_i
);
    logic [3:0] mem_q [ROWS*DIGITS];

    assign rdata_o = mem_q[raddr_i];

    // data memory keeps its contents across reset by design
    always_ff @(posedge core_clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

endmodule : nc_ram

`default_nettype wire

/* File: src/nc_decoder.sv */
// nc_decoder: fetch, decode and execute for the nibble core.
// assumes: pmem_data_i is the byte at addr_o in the same cycle.
//
// Contract
// [RULE1] add with carry, carry out, skip on carry
// [RULE2] add immediate, skip on carry, carry kept
// [RULE3] complement add with carry, skip on carry
// [RULE4] xor memory into accumulator, no skip
// [RULE5] indirect jump replaces low eight pc bits
// [RULE6] in-page jump, seven bits in pages 2-3
// [RULE7] page-two call pushes pc, jumps page 2
// [RULE8] return pops stack; 0x49 also skips
// [RULE9] load memory to accumulator, flip row
// [RULE10] swap accumulator with memory, flip row
// [RULE11] direct fetch or swap by second byte
// [RULE12] store immediate then step digit up
// [RULE13] swap, digit down, skip past zero
// [RULE14] swap, digit up, skip past fifteen
// [RULE15] table byte to output latch, copy level
// [RULE16] pointer loads; later consecutive ones skipped
// [RULE17] skip when general port is zero
// [RULE18] skip once per time-base carry
// [RULE19] pulse latches and osc pin to accumulator
// [RULE20] tri port split to memory and accumulator
// [RULE21] immediate value to general port
// [RULE22] serial swap, carry to clock latch
// [RULE23] skipped bytes each take one cycle
// [RULE24] unassigned bytes do nothing but advance
`timescale 1ns/1ps
`default_nettype none
`include "nc_params.svh"

module nc_decoder #(
    parameter int TB_DIV = `NC_TB_DIV
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  pmem_data_i,
    input  wire logic [7:0]  tri_port_i,
    input  wire logic        osc_out_pin_i,
    input  wire logic [1:0]  pulse_in_n_i,
    output logic      [10:0] addr_o,
    output logic      [3:0]  acc_o,
    output logic             carry_o,
    output logic      [7:0]  out_latch_o,
    output logic      [3:0]  general_port_o,
    output logic      [3:0]  shift_counter_reg_o,
    output logic             serial_clock_latch_o
);
    import nc_pkg::*;

    localparam int TW = $clog2(TB_DIV);

    function automatic logic [4:0] nc_add(input logic [3:0] a,
                                          input logic [3:0] b,
                                          input logic       ci);
        nc_add = {1'b0, a} + {1'b0, b} + {4'h0, ci};
    endfunction : nc_add

    nc_state_t  st_q, st_d;
    logic       skip_q, skip_d, ign_q, ign_d, lbi_q, lbi_d;
    logic [7:0] op1_q, op1_d, q_q, q_d;
    logic [3:0] acc_q, acc_d, bd_q, bd_d, g_q, g_d, sio_q, sio_d;
    logic [2:0] br_q, br_d;
    logic       c_q, c_d, skl_q, skl_d;
    logic [10:0] pc_q, pc_d, addr_q, addr_d;
    logic [TW-1:0] tb_q;
    logic       tick_q, tick_clr;
    logic [1:0] il_q, h1_q, h2_q;
    logic       il_clr;
    nc_stk_op_t stk_op;
    logic [10:0] stk_top;
    logic       ram_we;
    logic [6:0] ram_wa;
    logic [3:0] ram_wd, m;

    wire [7:0] op        = pmem_data_i;
    wire [3:0] hi        = op[7:4];
    wire [3:0] lo        = op[3:0];
    wire       ex1       = (st_q == ST_OP1) && !skip_q;
    wire       in_p23    = (pc_q[10:7] == `NC_PAGE_P23);
    wire       is_2byte  = (op == `NC_OP_DIRECT) || (op == `NC_OP_EXT)
                           || (hi == `NC_HI_JMP);
    wire       is_lbi1   = (op[7:6] == 2'h0) && op[3];
    wire       is_ramgrp = (op[7:6] == 2'h0) && (op[3:2] == 2'h1);
    wire       is_fixed  = (op == `NC_OP_TABLE_TO_OUTPUT_LATCH) || (op == `NC_OP_JID);
    wire       is_jp     = op[7] && !is_fixed && (in_p23 || op[6]);
    wire       is_page_two_call   = (op[7:6] == 2'h2) && !is_fixed && !in_p23;
    wire       is_immediate_add_skip   = (hi == `NC_HI_IMMEDIATE_ADD_SKIP) && (lo != 4'h0);
    wire       direct    = (st_q == ST_OP2) && (op1_q == `NC_OP_DIRECT);
    wire [6:0] ram_ra    = direct ? op[6:0] : {br_q, bd_q};
    wire [4:0] asc_sum   = nc_add(acc_q, m, c_q);
    wire [4:0] immediate_add_skip_sum  = nc_add(acc_q, lo, 1'b0);
    wire [4:0] complement_add_carry_sum  = nc_add(~acc_q, m, c_q);
    wire       asc_co    = asc_sum[4];
    wire       immediate_add_skip_co   = immediate_add_skip_sum[4];
    wire [3:0] complement_add_carry_lo   = complement_add_carry_sum[3:0];
    wire [3:0] xor_res   = acc_q ^ m;
    wire [3:0] bd_inc    = bd_q + 4'h1;
    wire [3:0] bd_dec    = bd_q - 4'h1;
    wire [2:0] row_flip  = br_q ^ {1'b0, op[5:4]};
    wire [10:0] pc_inc   = pc_q + 11'h001;
    wire [10:0] ind_addr = {pc_q[10:8], acc_q, m};
    wire [10:0] jp_tgt   = in_p23 ? {pc_q[10:7], op[6:0]}
                                  : {pc_q[10:6], op[5:0]};
    wire [10:0] call_tgt = {`NC_PAGE_CALL, op[5:0]};
    wire [10:0] jmp_tgt  = {op1_q[2:0], op};
    wire [10:0] ind_tgt  = {pc_q[10:8], op};
    wire       tb_wrap   = (tb_q == TW'(TB_DIV - 1));
    // low seen for two cycles after high: short glitches are ignored
    wire [1:0] il_set    = h2_q & ~h1_q & ~pulse_in_n_i;

    nc_ram u_ram (
        .core_clk_i (core_clk_i),
        .raddr_i    (ram_ra),
        .rdata_o    (m),
        .we_i       (ram_we),
        .waddr_i    (ram_wa),
        .wdata_i    (ram_wd)
    );

    nc_save_stack u_stack (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .op_i       (stk_op),
        .push_i     (pc_q),
        .top_o      (stk_top)
    );

    always_comb begin
        st_d = ST_OP1;   skip_d = 1'b0; ign_d = ign_q; lbi_d = lbi_q;
        op1_d = op1_q;   q_d = q_q;     acc_d = acc_q; bd_d = bd_q;
        g_d = g_q;       sio_d = sio_q; br_d = br_q;   c_d = c_q;
        skl_d = skl_q;   pc_d = pc_inc; addr_d = pc_q;
        stk_op = STK_HOLD; ram_we = 1'b0; ram_wa = {br_q, bd_q};
        ram_wd = acc_q;  tick_clr = 1'b0; il_clr = 1'b0;
        case (st_q)
            ST_OP1: begin
                if (skip_q) begin
                    if (is_2byte) begin // [RULE23]
                        st_d  = ST_OP2;
                        ign_d = 1'b1;
                    end
                end else if (is_2byte) begin
                    st_d  = ST_OP2;
                    op1_d = op;
                    ign_d = 1'b0;
                end else if (is_lbi1) begin
                    if (!lbi_q) begin // [RULE16]
                        br_d  = {1'b0, op[5:4]};
                        bd_d  = lo + 4'h1;
                        lbi_d = 1'b1;
                    end
                end else begin
                    lbi_d = 1'b0;
                    if (is_jp) begin // [RULE6]
                        addr_d = jp_tgt;
                        pc_d   = jp_tgt + 11'h001;
                    end else if (is_page_two_call) begin // [RULE7]
                        stk_op = STK_PUSH;
                        addr_d = call_tgt;
                        pc_d   = call_tgt + 11'h001;
                    end else if (is_ramgrp) begin
                        acc_d = m;
                        br_d  = row_flip; // [RULE9] [RULE10]
                        ram_we = (op[1:0] != `NC_LO_LD);
                        if (op[1:0] == `NC_LO_XIS) begin // [RULE14]
                            bd_d   = bd_inc;
                            skip_d = (bd_q == 4'hF);
                        end else if (op[1:0] == `NC_LO_XDS) begin // [RULE13]
                            bd_d   = bd_dec;
                            skip_d = (bd_q == 4'h0);
                        end
                    end else if (is_immediate_add_skip) begin // [RULE2]
                        acc_d  = immediate_add_skip_sum[3:0];
                        skip_d = immediate_add_skip_co;
                    end else if (hi == `NC_HI_STORE_IMMEDIATE_STEP) begin // [RULE12]
                        ram_we = 1'b1;
                        ram_wd = lo;
                        bd_d   = bd_inc;
                    end else begin
                        case (op)
                            `NC_OP_ASC: begin // [RULE1]
                                acc_d  = asc_sum[3:0];
                                c_d    = asc_co;
                                skip_d = asc_co;
                            end
                            `NC_OP_COMPLEMENT_ADD_CARRY: begin // [RULE3]
                                acc_d  = complement_add_carry_lo;
                                c_d    = complement_add_carry_sum[4];
                                skip_d = complement_add_carry_sum[4];
                            end
                            `NC_OP_XOR: acc_d = xor_res; // [RULE4]
                            `NC_OP_JID, `NC_OP_TABLE_TO_OUTPUT_LATCH: begin // [RULE5] [RULE15]
                                st_d   = ST_IND;
                                op1_d  = op;
                                addr_d = ind_addr;
                                pc_d   = pc_q;
                            end
                            `NC_OP_RET, `NC_OP_SUBROUTINE_EXIT_SKIP: begin // [RULE8]
                                stk_op = STK_POP;
                                addr_d = stk_top;
                                pc_d   = stk_top + 11'h001;
                                skip_d = (op == `NC_OP_SUBROUTINE_EXIT_SKIP);
                            end
                            `NC_OP_TICK: begin // [RULE18]
                                skip_d   = tick_q;
                                tick_clr = 1'b1;
                            end
                            `NC_OP_XAS: begin // [RULE22]
                                acc_d = sio_q;
                                sio_d = acc_q;
                                skl_d = c_q;
                            end
                            `NC_OP_CLRA: acc_d = 4'h0;
                            `NC_OP_RC:   c_d = 1'b0;
                            `NC_OP_SC:   c_d = 1'b1;
                            `NC_OP_SKC:  skip_d = c_q;
                            `NC_OP_SKE:  skip_d = (acc_q == m);
                            `NC_OP_COMP: acc_d = ~acc_q;
                            `NC_OP_ADD:  acc_d = asc_sum[3:0] - {3'h0, c_q};
                            `NC_OP_CAB:  bd_d = acc_q;
                            `NC_OP_CBA:  acc_d = bd_q;
                            default: ; // [RULE24]
                        endcase
                    end
                end
            end
            ST_OP2: begin
                if (!ign_q) begin
                    if (op1_q == `NC_OP_DIRECT) begin // [RULE11]
                        lbi_d  = 1'b0;
                        acc_d  = m;
                        ram_wa = op[6:0];
                        ram_we = op[7];
                    end else if (op1_q == `NC_OP_EXT) begin
                        if (op[7]) begin
                            if (!lbi_q) begin // [RULE16]
                                br_d  = op[6:4];
                                bd_d  = lo;
                                lbi_d = 1'b1;
                            end
                        end else begin
                            lbi_d = 1'b0;
                            if (op == `NC_X2_SKIP_PORT_ALL_ZERO) begin // [RULE17]
                                skip_d = (g_q == 4'h0);
                            end else if (op == `NC_X2_PULSE_LATCH_READ) begin // [RULE19]
                                acc_d  = {il_q[1], osc_out_pin_i, 1'b0, il_q[0]};
                                il_clr = 1'b1;
                            end else if (op == `NC_X2_INL) begin // [RULE20]
                                ram_we = 1'b1;
                                ram_wd = tri_port_i[7:4];
                                acc_d  = tri_port_i[3:0];
                            end else if (hi == `NC_HI_OGI) begin // [RULE21]
                                g_d = lo;
                            end
                        end
                    end else begin
                        lbi_d  = 1'b0;
                        stk_op = op1_q[3] ? STK_PUSH : STK_HOLD;
                        addr_d = jmp_tgt;
                        pc_d   = jmp_tgt + 11'h001;
                    end
                end
            end
            ST_IND: begin
                if (op1_q == `NC_OP_JID) begin // [RULE5]
                    addr_d = ind_tgt;
                    pc_d   = ind_tgt + 11'h001;
                end else begin // [RULE15]
                    q_d    = op;
                    stk_op = STK_DUPB;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_q <= ST_OP1;  skip_q <= 1'b0; ign_q <= 1'b0; lbi_q <= 1'b0;
            op1_q <= 8'h00;  q_q <= 8'h00;   acc_q <= 4'h0; bd_q <= 4'h0;
            g_q <= 4'h0;     sio_q <= 4'h0;  br_q <= 3'h0;  c_q <= 1'b0;
            skl_q <= 1'b0;   pc_q <= `NC_RST_PC + 11'h001;
            addr_q <= `NC_RST_PC;
        end else begin
            st_q <= st_d;    skip_q <= skip_d; ign_q <= ign_d; lbi_q <= lbi_d;
            op1_q <= op1_d;  q_q <= q_d;     acc_q <= acc_d; bd_q <= bd_d;
            g_q <= g_d;      sio_q <= sio_d; br_q <= br_d;   c_q <= c_d;
            skl_q <= skl_d;  pc_q <= pc_d;   addr_q <= addr_d;
        end
    end

    // set beats a same-cycle clear for tick and pulse latches
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tb_q <= '0;      tick_q <= 1'b0;
            il_q <= 2'h0;    h1_q <= 2'h3;   h2_q <= 2'h3;
        end else begin
            tb_q   <= tb_wrap ? '0 : tb_q + TW'(1);
            tick_q <= tb_wrap | (tick_q & ~tick_clr); // [RULE18]
            il_q   <= il_set | (il_q & ~{2{il_clr}});
            h1_q   <= pulse_in_n_i;
            h2_q   <= h1_q;
        end
    end

    assign addr_o               = addr_q;
    assign acc_o                = acc_q;
    assign carry_o              = c_q;
    assign out_latch_o          = q_q;
    assign general_port_o       = g_q;
    assign shift_counter_reg_o  = sio_q;
    assign serial_clock_latch_o = skl_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_asc;
        ex1 && (op == `NC_OP_ASC) |=> (c_q == $past(asc_co)) && (skip_q == $past(asc_co));
    endproperty
    a_asc: assert property (p_asc) else $error("add carry result wrong"); // [RULE1]

    property p_immediate_add_skip;
        ex1 && is_immediate_add_skip |=> (c_q == $past(c_q)) && (skip_q == $past(immediate_add_skip_co));
    endproperty
    a_immediate_add_skip: assert property (p_immediate_add_skip) else $error("immediate add wrong"); // [RULE2]

    property p_complement_add_carry;
        ex1 && (op == `NC_OP_COMPLEMENT_ADD_CARRY) |=> acc_q == $past(complement_add_carry_lo);
    endproperty
    a_complement_add_carry: assert property (p_complement_add_carry) else $error("complement add wrong"); // [RULE3]

    property p_xor;
        ex1 && (op == `NC_OP_XOR) |=> (acc_q == $past(xor_res)) && !skip_q;
    endproperty
    a_xor: assert property (p_xor) else $error("xor result wrong"); // [RULE4]

    property p_page_two_call;
        ex1 && is_page_two_call |=> addr_q[10:6] == `NC_PAGE_CALL;
    endproperty
    a_page_two_call: assert property (p_page_two_call) else $error("call missed page two"); // [RULE7]

    property p_subroutine_exit_skip;
        ex1 && (op == `NC_OP_SUBROUTINE_EXIT_SKIP) |=> skip_q && (addr_q == $past(stk_top));
    endproperty
    a_subroutine_exit_skip: assert property (p_subroutine_exit_skip) else $error("return skip wrong"); // [RULE8]

    property p_tick;
        ex1 && (op == `NC_OP_TICK) && tick_q && !tb_wrap |=> skip_q && !tick_q;
    endproperty
    a_tick: assert property (p_tick) else $error("tick test wrong"); // [RULE18]

    property p_xas;
        ex1 && (op == `NC_OP_XAS) |=> (skl_q == $past(c_q)) && (sio_q == $past(acc_q));
    endproperty
    a_xas: assert property (p_xas) else $error("serial swap wrong"); // [RULE22]

    property p_skip2;
        (st_q == ST_OP1) && skip_q && is_2byte |=> (st_q == ST_OP2) ##1 (st_q == ST_OP1);
    endproperty
    a_skip2: assert property (p_skip2) else $error("skip length wrong"); // [RULE23]

    property p_lbi;
        ex1 && is_lbi1 && lbi_q |=> (bd_q == $past(bd_q)) && lbi_q;
    endproperty
    a_lbi: assert property (p_lbi) else $error("chained load not skipped"); // [RULE16]

    property p_lbi2;
        (st_q == ST_OP2) && !ign_q && (op1_q == `NC_OP_EXT) && op[7]
            && lbi_q |=> (bd_q == $past(bd_q)) && (br_q == $past(br_q));
    endproperty
    a_lbi2: assert property (p_lbi2) else $error("chained long load ran"); // [RULE16]

endmodule : nc_decoder

`default_nettype wire

/* File: test/nc_pmem_model.sv */
// nc_pmem_model: external program memory holding the instruction bytes.
// assumes: the bench loads the image before reset is released.
`timescale 1ns/1ps
`default_nettype none

module nc_pmem_model (
    input  wire logic [10:0] addr_i,
    output logic      [7:0]  data_o
);
    logic [7:0] rom [2048];

    // unloaded words read as a plain no-op so stray fetches stay harmless
    initial begin
        for (int i = 0; i < 2048; i++) begin
            rom[i] = 8'h44;
        end
    end

    // combinational read: the byte must follow addr_i within the cycle
    assign data_o = rom[addr_i];
endmodule : nc_pmem_model

`default_nettype wire

/* File: test/tb_nc_decoder.sv */
// tb_nc_decoder: runs a short program and checks the core state per step.
// assumes: every byte takes one cycle and state shows after its edge.
`timescale 1ns/1ps
`default_nettype none

module tb_nc_decoder;
    logic        core_clk_i   = 1'b0;
    logic        rst_n_i      = 1'b0;
    logic [7:0]  pmem_data_i;
    logic [7:0]  tri_port_i   = 8'hA3;
    logic        osc_out_pin_i = 1'b1;
    logic [1:0]  pulse_in_n_i = 2'b11;
    logic [10:0] addr_o;
    logic [3:0]  acc_o;
    logic        carry_o;
    logic [7:0]  out_latch_o;
    logic [3:0]  general_port_o;
    logic [3:0]  shift_counter_reg_o;
    logic        serial_clock_latch_o;
    int          cyc        = 0;
    int          fails      = 0;
    int          n_compared = 0;

    nc_decoder #(.TB_DIV(16)) i_nc_decoder (
        .core_clk_i          (core_clk_i),
        .rst_n_i             (rst_n_i),
        .pmem_data_i         (pmem_data_i),
        .tri_port_i          (tri_port_i),
        .osc_out_pin_i       (osc_out_pin_i),
        .pulse_in_n_i        (pulse_in_n_i),
        .addr_o              (addr_o),
        .acc_o               (acc_o),
        .carry_o             (carry_o),
        .out_latch_o         (out_latch_o),
        .general_port_o      (general_port_o),
        .shift_counter_reg_o (shift_counter_reg_o),
        .serial_clock_latch_o(serial_clock_latch_o)
    );

    nc_pmem_model i_nc_pmem_model (
        .addr_i(addr_o),
        .data_o(pmem_data_i)
    );

    always #5 core_clk_i = ~core_clk_i;

    // counts executing edges since reset release
    always @(posedge core_clk_i) begin
        if (rst_n_i) begin
            cyc <= cyc + 1;
        end
    end

    // low pulse on the bit-1 input, four cycles long
    always @(posedge core_clk_i) begin
        pulse_in_n_i <= #1 (cyc >= 10 && cyc < 14) ? 2'b01 : 2'b11;
    end

    task automatic ld(input logic [10:0] a, input logic [7:0] q[$]);
        foreach (q[i]) begin
            i_nc_pmem_model.rom[a + 11'(i)] = q[i];
        end
    endtask : ld

    task automatic cmp(input string nm, input logic [10:0] e,
                       input logic [10:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // waits until step n has executed, then checks fetch address, accumulator, carry
    task automatic at(input int n, input logic [10:0] a,
                      input logic [3:0] ac, input logic c);
        while (cyc < n) begin
            @(posedge core_clk_i);
            #1;
        end
        cmp("addr_o", a, addr_o);
        cmp("acc_o", 11'(ac), 11'(acc_o));
        cmp("carry_o", 11'(c), 11'(carry_o));
    endtask : at

    task automatic report_and_stop;
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (200) @(posedge core_clk_i);
        fails++;
        report_and_stop();
    end

    initial begin
        // let the model fill its no-op image before the program goes in
        #1;
        ld(11'h000, '{8'h00,8'h33,8'h80,8'h75,8'h7F,8'h33,8'h80,8'h22,
                     8'h30,8'h30,8'h30,8'h5F,8'h02,8'h54,8'h57,8'h40,
                     8'h10,8'h33,8'h5F,8'h33,8'h5A,8'h33,8'h21,8'h4F,
                     8'h06,8'h05,8'h07,8'h40,8'h33,8'h8F,8'h73,8'h33,
                     8'h8F,8'h04,8'h40,8'h33,8'h81,8'h33,8'h8F,8'h05,
                     8'h81,8'h40,8'h23,8'h8F,8'h23,8'h0F,8'hFF});
        ld(11'h081, '{8'h49});
        ld(11'h0FF, '{8'h60});
        ld(11'h060, '{8'hC5});
        ld(11'h045, '{8'h41,8'h40,8'hBF,8'h33,8'h29,8'h33,8'h2E,8'h05});
        repeat (5) @(posedge core_clk_i);
        #1;
        rst_n_i = 1'b1;
        at(9, 11'h009, 4'h6, 1'b0);
        at(11, 11'h00B, 4'h0, 1'b1);
        at(12, 11'h00C, 4'h0, 1'b1);
        at(13, 11'h00D, 4'h5, 1'b1);
        at(14, 11'h00E, 4'h9, 1'b1);
        at(16, 11'h010, 4'h0, 1'b1);
        at(17, 11'h011, 4'h5, 1'b1);
        at(19, 11'h013, 4'h5, 1'b1);
        cmp("general_port_o", 11'h0, 11'(general_port_o));
        at(21, 11'h015, 4'h5, 1'b1);
        cmp("general_port_o", 11'hA, 11'(general_port_o));
        at(24, 11'h018, 4'h0, 1'b1);
        cmp("shift_counter_reg_o", 11'h5, 11'(shift_counter_reg_o));
        cmp("serial_clock_latch_o", 11'h1, 11'(serial_clock_latch_o));
        at(25, 11'h019, 4'h5, 1'b1);
        at(26, 11'h01A, 4'h0, 1'b1);
        at(28, 11'h01C, 4'h0, 1'b1);
        at(35, 11'h023, 4'h3, 1'b1);
        at(40, 11'h028, 4'hF, 1'b1);
        at(41, 11'h081, 4'hF, 1'b1);
        at(43, 11'h02A, 4'hF, 1'b1);
        at(45, 11'h02C, 4'h0, 1'b1);
        at(47, 11'h02E, 4'hF, 1'b1);
        at(48, 11'h0FF, 4'hF, 1'b1);
        at(49, 11'h060, 4'hF, 1'b1);
        at(50, 11'h045, 4'hF, 1'b1);
        at(52, 11'h047, 4'hF, 1'b1);
        at(54, 11'h048, 4'hF, 1'b1);
        cmp("out_latch_o", 11'h60, 11'(out_latch_o));
        at(56, 11'h04A, 4'hC, 1'b1);
        at(58, 11'h04C, 4'h3, 1'b1);
        at(59, 11'h04D, 4'hA, 1'b1);
        report_and_stop();
    end
endmodule : tb_nc_decoder

`default_nettype wire
